// [hw/clk_sup_cfg.svh]
// constants for the clock supervisor and watchdog block
// assumes 8-bit registers on a plain strobe port, one system clock domain
`ifndef CLK_SUP_CFG_SVH
`define CLK_SUP_CFG_SVH

// register offsets
`define OFS_WATCHDOG_CONTROL   4'h0
`define OFS_OSC_CONTROL        4'h1
`define OFS_IRQ_FLAGS_TWO      4'h2
`define OFS_RESET_CAUSE        4'h3

// field positions
`define WDC_WINDOW_BIT         7
`define WDC_SW_EN_BIT          0
`define OSC_INTERNAL_FREQ_SELECT_HI            6
`define OSC_INTERNAL_FREQ_SELECT_LO            4
`define OSC_PRIMARY_CLOCK_ACTIVE_FLAG_BIT           3
`define OSC_SCS_HI             1
`define OSC_SCS_LO             0
`define IRQ_OSC_FAIL_BIT       7
`define RCC_WINDOW_ERR_BIT     4
`define RCC_TIMEOUT_BIT        3

// reset values
`define RST_BYTE               8'h00
`define RST_INTERNAL_FREQ_SELECT               3'h0
`define RST_SCS                2'h0

// watchdog: 256 rc ticks make the nominal 4 ms base period
`define WDT_BASE_PERIOD_US     4000
`define WDT_CNT_LAST           8'hFF
`define WDT_WINDOW_START       8'hC0

// monitor sample clock is rc divided by 64
`define SAMPLE_DIV_RISE        6'h1F
`define SAMPLE_DIV_FALL        6'h3F

// system clock select codes
`define SCS_PRIMARY            2'h0
`define SCS_SECONDARY          2'h1

// primary oscillator mode codes of the crystal family
`define MODE_LOW_POWER_XTAL    4'h0
`define MODE_STANDARD_XTAL     4'h1
`define MODE_HIGH_SPEED_XTAL   4'h2
`define MODE_HS_PLL_XTAL       4'h6

`endif

// [hw/clk_sup_pkg.sv]
// types shared by the clock supervisor and its bench
// assumes clk_sup_cfg.svh holds every numeric constant
package clk_sup_pkg;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

  // config word one high
  typedef struct packed {
    logic       two_speed_enable;
    logic       fail_safe_enable_cfg;
    logic [1:0] unused;
    logic [3:0] primary_mode;
  } config_word_one_high_s;

  // watchdog config high
  typedef struct packed {
    logic [1:0] unused;
    logic       window_mode_cfg;
    logic [3:0] postscale_select;
    logic       config_watchdog_enable;
  } watchdog_config_high_s;

  typedef enum logic [1:0] {
    SRC_PRIMARY   = 2'b00,
    SRC_SECONDARY = 2'b01,
    SRC_RAW_RC    = 2'b10,
    SRC_OSC_MUX   = 2'b11
  } clk_src_e;

  typedef enum logic [2:0] {
    ST_START    = 3'b000,
    ST_PRIMARY  = 3'b001,
    ST_ALT      = 3'b010,
    ST_FAILSAFE = 3'b011,
    ST_SLEEP    = 3'b100
  } clk_state_e;

endpackage : clk_sup_pkg

// [hw/clock_supervisor_watchdog.sv]
// watchdog, two-speed start-up and fail-safe clock monitor in one block
// assumes rc, monitored clock and start-up-done come from outside clk_sys
// How it works
// R1 - watchdog ticks on rc, rc enabled with it
// R2 - sixteen-bit postscaler, select picks time-out tap
// R3 - sleep, clear, freq change, failure clear watchdog
// R4 - tuning rc rescales watchdog since it counts rc
// R5 - window mode: early clear causes reset
// R6 - window flag set when count at or above C0
// R7 - config enable forces watchdog; else software bit
// R8 - two-speed start needs its config enable bit
// R9 - two-speed start only in crystal modes
// R10 - run internal until start-up timer, then primary
// R11 - raw rc until software sets frequency select
// R12 - other modes keep selected source until primary
// R13 - select and sleep accepted during two-speed start
// R14 - active flag shows primary clock supplies system
// R15 - fail-safe enable keeps rc running continuously
// R16 - sample clock is rc divided by 64
// R17 - latch set on monitored fall, cleared sample rise
// R18 - failure when latch set at sample fall
// R19 - failure sets flag, goes internal, resets watchdog
// R20 - only primary and secondary clocks are monitored
// R21 - watchdog counter separate; rc stays on for monitor
// R22 - reset or power-managed entry ends fail-safe
// R23 - crystal start runs internal, monitor waits
// R24 - postscaler expiry without clear resets device
`timescale 1ns/1ps
`include "clk_sup_cfg.svh"

module clock_supervisor_watchdog (
  // clock and reset
  input  wire logic                               clk_sys,
  input  wire logic                               reset_n,
  // register port
  input  wire clk_sup_pkg::reg_req_s              reg_req,
  output logic [7:0]                              reg_rdata,
  // core events
  input  wire logic                               sleep_instr,
  input  wire logic                               clear_watchdog_instr,
  input  wire logic                               wake_event,
  // configuration words
  input  wire clk_sup_pkg::config_word_one_high_s config_word_one_high,
  input  wire clk_sup_pkg::watchdog_config_high_s watchdog_config_high,
  // pins from outside the clock domain
  input  wire logic                               internal_rc_osc,
  input  wire logic                               monitored_clk,
  input  wire logic                               osc_startup_timer_done,
  // clock control outputs
  output clk_sup_pkg::clk_src_e                   sys_clk_source,
  output logic                                    core_hold,
  output logic                                    internal_rc_enable,
  output logic                                    device_reset
);
  import clk_sup_pkg::*;

  typedef struct packed {
    logic [2:0]  rc_sync;
    logic [2:0]  mon_sync;
    logic [1:0]  rdy_sync;
    logic [5:0]  sample_div;
    logic        clock_monitor_latch;
    logic [7:0]  wdt_cnt;
    logic [15:0] wdt_post;
    logic        software_watchdog_enable;
    logic [2:0]  internal_freq_select;
    logic [1:0]  system_clock_select;
    logic        osc_fail_flag;
    logic        timeout_seen;
    logic        window_err_seen;
    clk_state_e  st;
    logic [7:0]  rdata;
    logic        dev_reset;
    clk_src_e    src;
    logic        hold;
    logic        rc_en;
  } state_s;

  state_s cur;
  state_s next_cur;

  function automatic logic is_crystal(input logic [3:0] mode);
    is_crystal = (mode == `MODE_LOW_POWER_XTAL) || (mode == `MODE_STANDARD_XTAL) ||
                 (mode == `MODE_HIGH_SPEED_XTAL) || (mode == `MODE_HS_PLL_XTAL);
  endfunction : is_crystal

  // internal source: raw rc until frequency select leaves zero
  function automatic clk_src_e internal_src(input logic [2:0] freq);
    internal_src = (freq == `RST_INTERNAL_FREQ_SELECT) ? SRC_RAW_RC : SRC_OSC_MUX;  // [R11]
  endfunction : internal_src

  // time-out tap: all low postscaler bits below the select are ones
  function automatic logic post_done(input logic [15:0] post, input logic [3:0] sel);
    logic [15:0] mask;
    mask = 16'hFFFF >> (5'h10 - {1'b0, sel});
    post_done = ((post & mask) == mask);
  endfunction : post_done

  logic rc_rise;
  logic mon_fall;
  logic osc_ready;
  logic fail_safe_monitor_en;
  logic wdt_on;
  logic crystal;
  logic in_window;
  logic mon_active;
  logic samp_rise;
  logic samp_fall;
  logic clock_fail;
  logic wdt_expire;
  logic window_err;
  logic wdt_clear;
  logic wr_wdc;
  logic wr_osc;
  logic wr_irq;
  logic wr_rcc;
  logic internal_freq_select_change;
  logic pm_entry;

  always_comb
  begin
    next_cur = cur;

    // pins: second stage feeds logic, third stage only for edges
    next_cur.rc_sync  = {cur.rc_sync[1:0], internal_rc_osc};
    next_cur.mon_sync = {cur.mon_sync[1:0], monitored_clk};
    next_cur.rdy_sync = {cur.rdy_sync[0], osc_startup_timer_done};
    rc_rise   = cur.rc_sync[1] & ~cur.rc_sync[2];
    mon_fall  = ~cur.mon_sync[1] & cur.mon_sync[2];
    osc_ready = cur.rdy_sync[1];

    fail_safe_monitor_en   = config_word_one_high.fail_safe_enable_cfg;
    crystal   = is_crystal(config_word_one_high.primary_mode);
    wdt_on    = watchdog_config_high.config_watchdog_enable |
                cur.software_watchdog_enable;  // [R7]
    in_window = (cur.wdt_cnt >= `WDT_WINDOW_START);  // [R6]

    wr_wdc = reg_req.wr && (reg_req.addr == `OFS_WATCHDOG_CONTROL);
    wr_osc = reg_req.wr && (reg_req.addr == `OFS_OSC_CONTROL);
    wr_irq = reg_req.wr && (reg_req.addr == `OFS_IRQ_FLAGS_TWO);
    wr_rcc = reg_req.wr && (reg_req.addr == `OFS_RESET_CAUSE);
    internal_freq_select_change = wr_osc &&
      (reg_req.wdata[`OSC_INTERNAL_FREQ_SELECT_HI:`OSC_INTERNAL_FREQ_SELECT_LO] != cur.internal_freq_select);
    pm_entry = sleep_instr ||
      (wr_osc && (reg_req.wdata[`OSC_SCS_HI:`OSC_SCS_LO] != `SCS_PRIMARY));

    // monitor: sample clock from its own divider; internal block never watched
    mon_active = fail_safe_monitor_en && ((cur.st == ST_PRIMARY) ||
                 ((cur.st == ST_ALT) &&
                  (cur.system_clock_select == `SCS_SECONDARY)));  // [R20] [R23]
    samp_rise  = rc_rise && (cur.sample_div == `SAMPLE_DIV_RISE);  // [R16]
    samp_fall  = rc_rise && (cur.sample_div == `SAMPLE_DIV_FALL);  // [R16]
    clock_fail = mon_active && samp_fall && cur.clock_monitor_latch;  // [R18]
    if (fail_safe_monitor_en && rc_rise)
    begin
      next_cur.sample_div = cur.sample_div + 6'h01;  // [R16]
    end
    if (!mon_active)
    begin
      next_cur.clock_monitor_latch = 1'b0;
    end
    else if (mon_fall)
    begin
      next_cur.clock_monitor_latch = 1'b1;  // [R17]
    end
    else if (samp_rise)
    begin
      next_cur.clock_monitor_latch = 1'b0;  // [R17]
    end

    // watchdog: counts rc ticks, so rc tuning scales its period too
    window_err = clear_watchdog_instr && wdt_on &&
                 !watchdog_config_high.window_mode_cfg && !in_window;  // [R5]
    wdt_expire = wdt_on && rc_rise && (cur.wdt_cnt == `WDT_CNT_LAST) &&
                 post_done(cur.wdt_post, watchdog_config_high.postscale_select);  // [R2]
    wdt_clear  = sleep_instr || clear_watchdog_instr || internal_freq_select_change ||
                 clock_fail || wdt_expire || !wdt_on;  // [R3] [R19]
    if (wdt_clear)
    begin
      next_cur.wdt_cnt  = 8'h00;  // [R3]
      next_cur.wdt_post = 16'h0000;  // [R3]
    end
    else if (rc_rise)
    begin
      next_cur.wdt_cnt = cur.wdt_cnt + 8'h01;  // [R1] [R4]
      if (cur.wdt_cnt == `WDT_CNT_LAST)
      begin
        next_cur.wdt_post = cur.wdt_post + 16'h0001;  // [R2]
      end
    end
    next_cur.dev_reset = wdt_expire || window_err;  // [R24] [R5]

    // software writes
    if (wr_wdc)
    begin
      next_cur.software_watchdog_enable = reg_req.wdata[`WDC_SW_EN_BIT];  // [R7]
    end
    if (wr_osc)
    begin
      next_cur.internal_freq_select = reg_req.wdata[`OSC_INTERNAL_FREQ_SELECT_HI:`OSC_INTERNAL_FREQ_SELECT_LO];
      next_cur.system_clock_select  = reg_req.wdata[`OSC_SCS_HI:`OSC_SCS_LO];  // [R13]
    end
    // sticky flags: hardware set wins over a software clear
    if (wr_irq && !reg_req.wdata[`IRQ_OSC_FAIL_BIT])
    begin
      next_cur.osc_fail_flag = 1'b0;
    end
    if (clock_fail)
    begin
      next_cur.osc_fail_flag = 1'b1;  // [R19]
    end
    if (wr_rcc)
    begin
      next_cur.timeout_seen    = cur.timeout_seen & reg_req.wdata[`RCC_TIMEOUT_BIT];
      next_cur.window_err_seen = cur.window_err_seen & reg_req.wdata[`RCC_WINDOW_ERR_BIT];
    end
    if (wdt_expire)
    begin
      next_cur.timeout_seen = 1'b1;
    end
    if (window_err)
    begin
      next_cur.window_err_seen = 1'b1;
    end

    // clock source sequencing
    case (cur.st)
      ST_START:
      begin
        if (sleep_instr)
        begin
          next_cur.st = ST_SLEEP;  // [R13]
        end
        else if (wr_osc && (reg_req.wdata[`OSC_SCS_HI:`OSC_SCS_LO] != `SCS_PRIMARY))
        begin
          next_cur.st = ST_ALT;  // [R13]
        end
        else if (!crystal || osc_ready)
        begin
          next_cur.st = ST_PRIMARY;  // [R10] [R23]
        end
      end
      ST_PRIMARY:
      begin
        if (clock_fail)
        begin
          next_cur.st = ST_FAILSAFE;  // [R19]
        end
        else if (sleep_instr)
        begin
          next_cur.st = ST_SLEEP;
        end
        else if (pm_entry)
        begin
          next_cur.st = ST_ALT;
        end
      end
      ST_ALT:
      begin
        if (clock_fail)
        begin
          next_cur.st = ST_FAILSAFE;  // [R19]
        end
        else if (sleep_instr)
        begin
          next_cur.st = ST_SLEEP;
        end
        else if ((cur.system_clock_select == `SCS_PRIMARY) && (!crystal || osc_ready))
        begin
          next_cur.st = ST_PRIMARY;  // [R12]
        end
      end
      ST_FAILSAFE:
      begin
        // failed source is never re-selected by itself
        if (sleep_instr)
        begin
          next_cur.st = ST_SLEEP;  // [R22]
        end
        else if (pm_entry)
        begin
          next_cur.st = ST_ALT;  // [R22]
        end
      end
      ST_SLEEP:
      begin
        if (wake_event)
        begin
          next_cur.st = (cur.system_clock_select == `SCS_PRIMARY) ? ST_START : ST_ALT;
        end
      end
      default:
      begin
        next_cur.st = ST_START;
      end
    endcase

    // source and hold follow the next state so outputs move with it
    next_cur.hold = 1'b0;
    case (next_cur.st)
      ST_START:
      begin
        next_cur.src  = internal_src(next_cur.internal_freq_select);  // [R10] [R11]
        // without two-speed start the core waits for the crystal
        next_cur.hold = crystal && !config_word_one_high.two_speed_enable;  // [R8] [R9]
      end
      ST_PRIMARY:
      begin
        next_cur.src = SRC_PRIMARY;  // [R14]
      end
      ST_ALT:
      begin
        // primary still starting: the selected source keeps running
        case (next_cur.system_clock_select)
          `SCS_PRIMARY:   next_cur.src = internal_src(next_cur.internal_freq_select);  // [R12]
          `SCS_SECONDARY: next_cur.src = SRC_SECONDARY;
          default:        next_cur.src = internal_src(next_cur.internal_freq_select);
        endcase
      end
      ST_FAILSAFE:
      begin
        next_cur.src = internal_src(next_cur.internal_freq_select);  // [R19]
      end
      default:
      begin
        next_cur.src = cur.src;
      end
    endcase

    // rc runs for watchdog, monitor, or as the clock itself
    next_cur.rc_en = wdt_on || fail_safe_monitor_en || (next_cur.src == SRC_RAW_RC) ||
                     (next_cur.src == SRC_OSC_MUX);  // [R1] [R15] [R21]

    // read data stands only in the cycle after the strobe
    next_cur.rdata = `RST_BYTE;
    if (reg_req.rd)
    begin
      case (reg_req.addr)
        `OFS_WATCHDOG_CONTROL:
        begin
          next_cur.rdata[`WDC_WINDOW_BIT] = in_window;  // [R6]
          next_cur.rdata[`WDC_SW_EN_BIT]  = cur.software_watchdog_enable;
        end
        `OFS_OSC_CONTROL:
        begin
          next_cur.rdata[`OSC_INTERNAL_FREQ_SELECT_HI:`OSC_INTERNAL_FREQ_SELECT_LO] = cur.internal_freq_select;
          next_cur.rdata[`OSC_PRIMARY_CLOCK_ACTIVE_FLAG_BIT] = (cur.src == SRC_PRIMARY);  // [R14]
          next_cur.rdata[`OSC_SCS_HI:`OSC_SCS_LO] = cur.system_clock_select;
        end
        `OFS_IRQ_FLAGS_TWO:
        begin
          next_cur.rdata[`IRQ_OSC_FAIL_BIT] = cur.osc_fail_flag;
        end
        `OFS_RESET_CAUSE:
        begin
          next_cur.rdata[`RCC_TIMEOUT_BIT]    = cur.timeout_seen;
          next_cur.rdata[`RCC_WINDOW_ERR_BIT] = cur.window_err_seen;
        end
        default:
        begin
          next_cur.rdata = `RST_BYTE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cur <= '0;
      cur.st <= ST_START;  // [R22]
      cur.src <= SRC_RAW_RC;  // [R11]
      cur.internal_freq_select <= `RST_INTERNAL_FREQ_SELECT;
      cur.system_clock_select  <= `RST_SCS;
      cur.rc_en <= 1'b1;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign reg_rdata          = cur.rdata;
  assign sys_clk_source     = cur.src;
  assign core_hold          = cur.hold;
  assign internal_rc_enable = cur.rc_en;
  assign device_reset       = cur.dev_reset;

endmodule : clock_supervisor_watchdog

// [sim/clock_supervisor_watchdog_properties.sv]
// port assertions for the clock supervisor
// assumes a bind from the bench, one clk_sys domain
`timescale 1ns/1ps
`include "clk_sup_cfg.svh"
module clk_sup_props
  import clk_sup_pkg::*;
(
  // clock and reset
  input wire logic                                clk_sys,
  input wire logic                                reset_n,
  // register port
  input wire clk_sup_pkg::reg_req_s               reg_req,
  input wire logic [7:0]                          reg_rdata,
  // events and configuration
  input wire logic                                clear_watchdog_instr,
  input wire clk_sup_pkg::config_word_one_high_s  config_word_one_high,
  input wire clk_sup_pkg::watchdog_config_high_s  watchdog_config_high,
  input wire logic                                osc_startup_timer_done,
  // clock control outputs
  input wire clk_sup_pkg::clk_src_e               sys_clk_source,
  input wire logic                                internal_rc_enable,
  input wire logic                                device_reset
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  a_pulse_single:
    assert property (device_reset |=> !device_reset) else $error("reset pulse too long");
  a_raw_after_reset:
    assert property ($rose(reset_n) |-> sys_clk_source == SRC_RAW_RC)
    else $error("not on raw rc after reset");
  // rc enable is registered, so it trails a config change by one cycle
  a_rc_for_monitor:
    assert property (config_word_one_high.fail_safe_enable_cfg |=> internal_rc_enable)
    else $error("rc off with monitor on");
  a_rc_for_watchdog:
    assert property (watchdog_config_high.config_watchdog_enable |=> internal_rc_enable)
    else $error("rc off with watchdog forced");
  // expiry in the clear cycle itself may still land, hence the skipped cycle
  a_quiet_after_clear:
    assert property (clear_watchdog_instr && watchdog_config_high.window_mode_cfg
      |=> ##1 !device_reset [*8]) else $error("reset soon after clear");
  a_primary_needs_ready:
    assert property (!osc_startup_timer_done |-> sys_clk_source != SRC_PRIMARY)
    else $error("primary used before ready");
  a_window_bits_zero:
    assert property (reg_req.rd && reg_req.addr == `OFS_WATCHDOG_CONTROL
      |=> reg_rdata[6:1] == 6'h00) else $error("unused control bits set");
  a_active_flag:
    assert property (reg_req.rd && reg_req.addr == `OFS_OSC_CONTROL && $stable(sys_clk_source)
      |=> ($stable(sys_clk_source)
      -> (reg_rdata[`OSC_PRIMARY_CLOCK_ACTIVE_FLAG_BIT] == (sys_clk_source == SRC_PRIMARY))))
    else $error("active flag wrong");
endmodule : clk_sup_props

// [sim/ext_osc_model.sv]
// external crystal seen by the supervisor
// assumes it restarts whenever the device is reset
`timescale 1ns/1ps
module ext_osc_model #(
  parameter int START_NS = 20000,
  parameter int HALF_NS  = 150
) (
  // device reset
  input  wire logic reset_n,
  // oscillator pins
  output logic      monitored_clk,
  output logic      osc_startup_timer_done
);
  initial
  begin
    monitored_clk = 1'b0;
    osc_startup_timer_done = 1'b0;
  end
  // not ready until the start-up delay has run out
  always @(negedge reset_n) osc_startup_timer_done = 1'b0;
  always @(posedge reset_n) #(START_NS) osc_startup_timer_done = 1'b1;
  // no oscillation before the crystal has built up; stands low then
  always #(HALF_NS) monitored_clk = osc_startup_timer_done & ~monitored_clk;
endmodule : ext_osc_model

// [sim/clock_supervisor_watchdog_bench.sv]
// self-checking bench for the clock supervisor
// assumes 20 MHz clk_sys and a free-running rc of 406 ns period
`timescale 1ns/1ps
`include "clk_sup_cfg.svh"
module clock_supervisor_watchdog_bench;
  import clk_sup_pkg::*;
  logic                  clk_sys = 1'b0;
  logic                  reset_n = 1'b0;
  reg_req_s              reg_req = '0;
  logic [7:0]            reg_rdata;
  logic                  sleep_instr = 1'b0;
  logic                  clear_watchdog_instr = 1'b0;
  logic                  wake_event = 1'b0;
  config_word_one_high_s cfg1 = 8'h81;
  watchdog_config_high_s cfg2 = 8'h20;
  logic                  rc = 1'b0;
  logic                  mclk;
  logic                  done;
  clk_src_e              src;
  logic                  core_hold;
  logic                  rc_en;
  logic                  device_reset;
  int                    fails = 0;
  int                    n_compared = 0;
  int                    resets = 0;
  int                    k;
  int                    r0;
  logic [7:0]            v;

  always #25 clk_sys = ~clk_sys;
  always #203 rc = ~rc;
  always @(posedge clk_sys) if (device_reset === 1'b1) resets <= resets + 1;

  clock_supervisor_watchdog uut (
    .clk_sys, .reset_n, .reg_req, .reg_rdata, .sleep_instr, .clear_watchdog_instr,
    .wake_event, .config_word_one_high(cfg1), .watchdog_config_high(cfg2),
    .internal_rc_osc(rc), .monitored_clk(mclk), .osc_startup_timer_done(done),
    .sys_clk_source(src), .core_hold, .internal_rc_enable(rc_en), .device_reset
  );
  ext_osc_model #(.START_NS(20000), .HALF_NS(150)) xtal (
    .reset_n, .monitored_clk(mclk), .osc_startup_timer_done(done)
  );

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_req <= '{a, d, 1'b1, 1'b0};
    tick(1);
    reg_req <= '0;
    tick(1);
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    reg_req <= '{a, 8'h00, 1'b0, 1'b1};
    tick(1);
    reg_req <= '0;
    #1 v = reg_rdata;
    tick(1);
  endtask : rd

  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    rd(a);
    check($sformatf("reg %0d", a), v, e);
  endtask : rchk

  task automatic pulse(input int which);
    clear_watchdog_instr <= (which == 0);
    sleep_instr <= (which == 1);
    wake_event <= (which == 2);
    tick(1);
    clear_watchdog_instr <= 1'b0;
    sleep_instr <= 1'b0;
    wake_event <= 1'b0;
  endtask : pulse

  // 0: next reset pulse, 1: source turns primary, 2: source leaves primary
  task automatic wait_for(input int what, input int lim);
    k = 0;
    r0 = resets;
    while (k < lim && (what == 0 ? resets == r0 : (src == SRC_PRIMARY) != (what == 1)))
    begin
      tick(1);
      k++;
    end
    if (k >= lim)
    begin
      fails++;
      wrap_up();
    end
  endtask : wait_for

  initial
  begin
    tick(10);
    reset_n <= 1'b1;
    tick(1);
    for (int a = 0; a < 5; a++) rchk(4'(a), 8'h00);
    check("source", 8'(src), 8'(SRC_RAW_RC));
    check("hold", 8'(core_hold), 8'h00);
    wait_for(1, 2000);
    check("late switch", 8'(k > 350), 8'h01);
    rchk(`OFS_OSC_CONTROL, 8'h08);
    // select 0 forced by config, select 1 by software bit
    for (int n = 0; n < 2; n++)
    begin
      cfg2 <= {2'b00, 1'b1, 4'(n), n == 0};
      if (n == 1) wr(`OFS_WATCHDOG_CONTROL, 8'h01);
      pulse(0);
      wait_for(0, 9000);
      check("period", 8'(k >= (2000 << n) && k <= (2150 << n)), 8'h01);
    end
    rchk(`OFS_RESET_CAUSE, 8'h08);
    wr(`OFS_RESET_CAUSE, 8'h00);
    rchk(`OFS_RESET_CAUSE, 8'h00);
    pulse(0);
    r0 = resets;
    // gaps under one period, two gaps over it: a lost clear shows as a reset
    for (int e = 0; e < 3; e++)
    begin
      tick(3000);
      if (e == 0) pulse(0);
      if (e == 1) pulse(1);
      if (e == 1) tick(4);
      if (e == 1) pulse(2);
      if (e == 2) wr(`OFS_OSC_CONTROL, 8'h70);
    end
    tick(3000);
    check("cleared", 8'(resets - r0), 8'h00);
    wr(`OFS_WATCHDOG_CONTROL, 8'h00);
    r0 = resets;
    tick(5000);
    check("off", 8'(resets - r0), 8'h00);
    check("rc idle", 8'(rc_en), 8'h00);
    cfg2 <= 8'h00;
    wr(`OFS_WATCHDOG_CONTROL, 8'h01);
    r0 = resets;
    pulse(0);
    tick(3);
    check("early clear", 8'(resets - r0), 8'h01);
    rchk(`OFS_RESET_CAUSE, 8'h10);
    k = 0;
    v = 8'h00;
    while (!v[7] && k < 3000)
    begin
      rd(`OFS_WATCHDOG_CONTROL);
      check("control low bits", {1'b0, v[6:0]}, 8'h01);
      k += 2;
    end
    check("flag", v, 8'h81);
    check("window", 8'(k >= 1480 && k <= 1680), 8'h01);
    r0 = resets;
    pulse(0);
    tick(3);
    check("late clear", 8'(resets - r0), 8'h00);
    wr(`OFS_WATCHDOG_CONTROL, 8'h00);
    cfg2 <= 8'h20;
    // latch polarity as specified: a live clock leaves it set
    cfg1 <= 8'hC1;
    wait_for(2, 3000);
    check("backup", 8'(src[1]), 8'h01);
    check("rc kept", 8'(rc_en), 8'h01);
    rchk(`OFS_IRQ_FLAGS_TWO, 8'h80);
    rchk(`OFS_OSC_CONTROL, 8'h70);
    wr(`OFS_IRQ_FLAGS_TWO, 8'h00);
    rchk(`OFS_IRQ_FLAGS_TWO, 8'h00);
    wr(`OFS_OSC_CONTROL, 8'h71);
    check("secondary", 8'(src), 8'(SRC_SECONDARY));
    cfg1 <= 8'h41;
    reset_n <= 1'b0;
    tick(2);
    reset_n <= 1'b1;
    tick(10);
    check("held", 8'(core_hold), 8'h01);
    wait_for(1, 2000);
    check("released", 8'(core_hold), 8'h00);
    rchk(`OFS_OSC_CONTROL, 8'h08);
    wrap_up();
  end
endmodule : clock_supervisor_watchdog_bench

bind clock_supervisor_watchdog clk_sup_props props (
  .clk_sys, .reset_n, .reg_req, .reg_rdata, .clear_watchdog_instr, .config_word_one_high,
  .watchdog_config_high, .osc_startup_timer_done, .sys_clk_source, .internal_rc_enable,
  .device_reset
);
